/* hdl/pba_arbiter.sv */
// Secondary bus arbiter, secondary and primary bus parking, register port
module pba_arbiter (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        central_function_sel_n,
	input  wire logic [8:0]  sec_req_n,
	output logic      [8:0]  sec_gnt_n,
	input  wire logic        sec_frame_n,
	input  wire logic        sec_initiator_ready_n,
	input  wire logic        bridge_sec_req,
	output logic             bridge_sec_gnt,
	output logic             sec_ad_oe,
	output logic             sec_cbe_oe,
	output logic             sec_par_oe,
	input  wire logic        pri_pending,
	input  wire logic        pri_target_end,
	input  wire logic        pri_gnt_n,
	input  wire logic        pri_frame_n,
	input  wire logic        pri_irdy_n,
	output logic             pri_req_n,
	output logic             pri_frame_start,
	output logic             pri_ad_oe,
	output logic             pri_cmd_byte_en_oe,
	output logic             pri_parity_oe,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);
	logic [9:0]  prio_reg;
	logic        park_bridge_reg;
	logic        preempt_dis_reg;
	logic [2:0]  tp_sel_reg;
	logic        gnt_on_reg;
	logic [3:0]  owner_reg;
	logic        gnt_on_next;
	logic [3:0]  owner_next;
	logic [3:0]  hi_last_reg;
	logic [3:0]  lo_last_reg;
	logic        frame_n_q_reg;
	logic [1:0]  backoff_reg;
	logic        ext_mode;
	logic        flat;
	logic        bus_idle;
	logic        frame_start;
	logic [9:0]  req_vec;
	logic [9:0]  lo_vec;
	logic [10:0] hi_vec;
	logic        hi_found;
	logic [3:0]  hi_pick;
	logic        lo_found;
	logic [3:0]  lo_pick;
	logic        win_valid;
	logic [3:0]  win_idx;
	logic [3:0]  target_idx;
	logic [4:0]  tmo_cnt;
	logic        tmo_inc;
	logic        timeout_hit;
	logic [6:0]  pre_cnt;
	logic        pre_inc;
	logic [6:0]  tp_clocks;
	logic        preempt_go;
	logic        park_sec;
	logic        park_pri;
	logic        pri_idle;
	logic [9:0]  gvec;
	logic        prev_gnt_on_reg;
	logic [3:0]  prev_owner_reg;
	logic        init_on;
	logic [3:0]  init_idx;

	assign ext_mode    = central_function_sel_n;
	assign bus_idle    = sec_frame_n && sec_initiator_ready_n;
	assign frame_start = !sec_frame_n && frame_n_q_reg;
	assign req_vec     = {bridge_sec_req, ~sec_req_n};
	assign gvec        = {bridge_sec_gnt, ~sec_gnt_n};

	// Register writes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prio_reg        <= pba_pkg::PRIO_RST;
			park_bridge_reg <= 1'b0;
			preempt_dis_reg <= 1'b0;
			tp_sel_reg      <= pba_pkg::TP_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				pba_pkg::OFF_PRIO: begin
					prio_reg <= reg_wdata[9:0];
				end
				pba_pkg::OFF_PARK: begin
					park_bridge_reg <= reg_wdata[pba_pkg::PARK_BIT];
				end
				pba_pkg::OFF_PREEMPT: begin
					preempt_dis_reg <= reg_wdata[pba_pkg::PREEMPT_OFF_BIT];
					tp_sel_reg      <= reg_wdata[pba_pkg::TP_LSB +: pba_pkg::TP_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data stand for exactly one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				pba_pkg::OFF_PRIO:    reg_rdata <= {22'h0, prio_reg};
				pba_pkg::OFF_PARK:    reg_rdata <= {30'h0, park_bridge_reg, 1'b0};
				pba_pkg::OFF_PREEMPT: reg_rdata <= {preempt_dis_reg, 28'h0, tp_sel_reg};
				pba_pkg::OFF_STATUS:  reg_rdata <= {25'h0, flat, ext_mode, gnt_on_reg,
					owner_reg};
				default:              reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// Group vectors; low group is slot 10 of the high rotation
	always_comb begin
		flat = (prio_reg == 10'h000) || (prio_reg == 10'h3FF);
		if (flat) begin
			lo_vec = req_vec;
			hi_vec = {|req_vec, 10'h000};
		end else begin
			lo_vec = req_vec & ~prio_reg;
			hi_vec = {|lo_vec, req_vec & prio_reg};
		end
	end

	pba_rr_pick #(
		.N (11),
		.W (4)
	) u_hi_pick (
		.req_vec  (hi_vec),
		.last_idx (hi_last_reg),
		.found    (hi_found),
		.pick_idx (hi_pick)
	);

	pba_rr_pick #(
		.N (10),
		.W (4)
	) u_lo_pick (
		.req_vec  (lo_vec),
		.last_idx (lo_last_reg),
		.found    (lo_found),
		.pick_idx (lo_pick)
	);

	always_comb begin
		win_valid = hi_found && (hi_pick != pba_pkg::LOW_SLOT || lo_found);
		win_idx   = (hi_pick == pba_pkg::LOW_SLOT) ? lo_pick : hi_pick;
		if (win_valid) begin
			target_idx = win_idx;
		end else if (park_bridge_reg) begin
			target_idx = pba_pkg::BRIDGE_IDX;
		end else begin
			target_idx = owner_reg;
		end
	end

	// Time-to-preempt decode
	always_comb begin
		case (tp_sel_reg)
			3'h0:    tp_clocks = 7'h00;
			3'h1:    tp_clocks = 7'h01;
			3'h2:    tp_clocks = 7'h02;
			3'h3:    tp_clocks = 7'h04;
			3'h4:    tp_clocks = 7'h08;
			3'h5:    tp_clocks = 7'h10;
			3'h6:    tp_clocks = 7'h20;
			3'h7:    tp_clocks = 7'h40;
			default: tp_clocks = 7'h00;
		endcase
	end

	assign tmo_inc = !ext_mode && gnt_on_reg && bus_idle && !frame_start
		&& req_vec[owner_reg];
	assign timeout_hit = tmo_inc && (tmo_cnt == pba_pkg::GNT_TIMEOUT - 5'h01);
	assign pre_inc = !ext_mode && gnt_on_reg && !bus_idle && win_valid
		&& (win_idx != owner_reg);
	assign preempt_go = !preempt_dis_reg && (pre_cnt >= tp_clocks);

	pba_cnt #(
		.W (pba_pkg::TMO_W)
	) u_tmo_cnt (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.clear   (!tmo_inc),
		.inc     (tmo_inc),
		.count   (tmo_cnt)
	);

	pba_cnt #(
		.W (pba_pkg::PRE_W)
	) u_pre_cnt (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.clear   (!pre_inc),
		.inc     (pre_inc),
		.count   (pre_cnt)
	);

	// Grant ownership
	always_comb begin
		gnt_on_next = gnt_on_reg;
		owner_next  = owner_reg;
		if (ext_mode) begin
			gnt_on_next = 1'b0;
			owner_next  = pba_pkg::BRIDGE_IDX;
		end else if (timeout_hit) begin
			gnt_on_next = 1'b0;
		end else if (!gnt_on_reg) begin
			gnt_on_next = 1'b1;
			owner_next  = target_idx;
		end else if (target_idx != owner_reg) begin
			if (bus_idle) begin
				gnt_on_next = 1'b0;
			end else if (preempt_go) begin
				owner_next = target_idx;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			gnt_on_reg      <= 1'b1;
			owner_reg       <= pba_pkg::BRIDGE_IDX;
			prev_gnt_on_reg <= 1'b1;
			prev_owner_reg  <= pba_pkg::BRIDGE_IDX;
		end else begin
			gnt_on_reg      <= gnt_on_next;
			owner_reg       <= owner_next;
			prev_gnt_on_reg <= gnt_on_reg;
			prev_owner_reg  <= owner_reg;
		end
	end

	// Initiator sampled its grant the cycle before frame was seen low
	assign init_on  = frame_start ? prev_gnt_on_reg : (gnt_on_reg && timeout_hit);
	assign init_idx = frame_start ? prev_owner_reg : owner_reg;

	// Rotation pointers move past the last initiator
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hi_last_reg <= pba_pkg::LOW_SLOT;
			lo_last_reg <= 4'h8;
		end else if (!ext_mode && init_on) begin
			if (flat) begin
				lo_last_reg <= init_idx;
			end else if (prio_reg[init_idx]) begin
				hi_last_reg <= init_idx;
			end else begin
				lo_last_reg <= init_idx;
				hi_last_reg <= pba_pkg::LOW_SLOT;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			frame_n_q_reg <= 1'b1;
		end else begin
			frame_n_q_reg <= sec_frame_n;
		end
	end

	// Grant pins
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sec_gnt_n      <= 9'h1FF;
			bridge_sec_gnt <= 1'b0;
		end else if (ext_mode) begin
			sec_gnt_n      <= {8'hFF, !bridge_sec_req};
			bridge_sec_gnt <= !sec_req_n[0] && bridge_sec_req;
		end else begin
			for (int i = 0; i < pba_pkg::NUM_EXT; i++) begin
				sec_gnt_n[i] <= !(gnt_on_next && owner_next == 4'(i));
			end
			bridge_sec_gnt <= gnt_on_next && owner_next == pba_pkg::BRIDGE_IDX;
		end
	end

	// Secondary parking
	assign park_sec = bus_idle && !bridge_sec_req && (ext_mode ? !sec_req_n[0]
		: (gnt_on_reg && owner_reg == pba_pkg::BRIDGE_IDX));

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sec_ad_oe  <= 1'b0;
			sec_cbe_oe <= 1'b0;
			sec_par_oe <= 1'b0;
		end else begin
			sec_ad_oe  <= park_sec;
			sec_cbe_oe <= park_sec;
			sec_par_oe <= park_sec && sec_ad_oe;
		end
	end

	// Primary request with back-off after target termination
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			backoff_reg <= 2'h0;
			pri_req_n   <= 1'b1;
		end else if (pri_target_end) begin
			backoff_reg <= pba_pkg::PRI_BACKOFF - 2'h1;
			pri_req_n   <= 1'b1;
		end else if (backoff_reg != 2'h0) begin
			backoff_reg <= backoff_reg - 2'h1;
			pri_req_n   <= 1'b1;
		end else begin
			pri_req_n   <= !pri_pending;
		end
	end

	// Primary parking and transaction start
	assign pri_idle = pri_frame_n && pri_irdy_n;
	assign park_pri = !pri_gnt_n && pri_req_n && pri_idle;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pri_ad_oe          <= 1'b0;
			pri_cmd_byte_en_oe <= 1'b0;
			pri_parity_oe      <= 1'b0;
			pri_frame_start    <= 1'b0;
		end else begin
			pri_ad_oe          <= park_pri;
			pri_cmd_byte_en_oe <= park_pri;
			pri_parity_oe      <= park_pri && pri_ad_oe;
			pri_frame_start    <= !pri_gnt_n && pri_idle && pri_pending
				&& (!pri_req_n || pri_ad_oe);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_ext_unused_high: assert property (ext_mode |=> sec_gnt_n[8:1] == 8'hFF)
		else $error("unused grants not high in external mode");
	a_ext_req_out: assert property (ext_mode && $past(ext_mode) |->
		sec_gnt_n[0] == !$past(bridge_sec_req))
		else $error("grant 0 does not carry the bridge request");
	a_one_grant: assert property (!ext_mode |-> $countones(gvec) <= 1)
		else $error("more than one grant asserted");
	a_idle_no_swap: assert property (!ext_mode && $past(!ext_mode) && $past(bus_idle)
		&& $past(gvec) != 10'h000 && gvec != 10'h000 |-> gvec == $past(gvec))
		else $error("grant swapped in one clock on idle bus");
	a_timeout_drop: assert property (timeout_hit |=> !gnt_on_reg ##1 gnt_on_reg)
		else $error("grant not withdrawn after timeout");
	a_sec_par_lag: assert property ($rose(sec_par_oe) |-> $past(sec_ad_oe) && sec_ad_oe)
		else $error("parity driven before address");
	a_pri_park_drop: assert property (pri_gnt_n |=> !pri_ad_oe && !pri_parity_oe)
		else $error("primary bus still driven after grant removed");
	a_pri_backoff: assert property (pri_target_end |=> pri_req_n [*2])
		else $error("primary request not dropped two clocks");
	a_pri_start_gnt: assert property (pri_frame_start |-> $past(!pri_gnt_n))
		else $error("primary start without grant");
	a_ext_start: assert property (ext_mode && $past(ext_mode) && !sec_req_n[0]
		&& bridge_sec_req |=> bridge_sec_gnt)
		else $error("bridge not started after external grant");
endmodule : pba_arbiter

/* hdl/pba_pkg.sv */
// Constants for the secondary bus arbiter and bus parking block
// Functional notes
// - Central-function pin low enables internal arbiter for nine request/grant pairs.
// - Two-level rotation; whole low group is one slot in high rotation.
// - Priority register at 40h holds one bit per master; 1 high, 0 low.
// - All masters in one group gives plain round-robin among all.
// - After reset external masters are low priority, bridge is high priority.
// - Priorities recomputed at each frame start; highest asserted request gets grant.
// - Higher request during lower grant moves grant on the next clock.
// - Previous initiator drops to lowest in its group; next master becomes top.
// - Grant withdrawn after 16 idle granted cycles without frame.
// - On idle bus, new grant comes at least one clock after old removed.
// - On busy bus, grants may swap within the same clock.
// - Preemption enabled by default; bit 31 at 4Ch set disables it.
// - Time-to-preempt selectable 0,1,2,4,8,16,32,64 clocks, default 0.
// - Owner loses grant once waiting master has waited time-to-preempt.
// - Pin high disables arbiter; grant 0 is request out, request 0 is grant in.
// - External mode: bridge starts transaction one cycle after external grant.
// - External mode: grant without own request on idle bus parks the bus.
// - External mode drives grant outputs 8 to 1 high; board pulls requests high.
// - Parking drives address and command first, parity one cycle later.
// - Primary parked only with grant, no request, idle bus; released after grant.
// - While parking primary with work pending, frame may start next clock.
// - Grant stays with last master; bridge parks after reset; 48h bit 1 forces bridge.
// - Primary request held while work queued; dropped two clocks after target end.
package pba_pkg;
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFF_PRIO        = 8'h40;
	localparam logic [7:0]  OFF_PARK        = 8'h48;
	localparam logic [7:0]  OFF_PREEMPT     = 8'h4C;
	localparam logic [7:0]  OFF_STATUS      = 8'h50;
	localparam int          NUM_EXT         = 9;
	localparam int          NUM_MST         = 10;
	localparam int          IDX_W           = 4;
	localparam logic [3:0]  BRIDGE_IDX      = 4'h9;
	localparam logic [3:0]  LOW_SLOT        = 4'hA;
	localparam logic [9:0]  PRIO_RST        = 10'h200;
	localparam int          PARK_BIT        = 1;
	localparam int          PREEMPT_OFF_BIT = 31;
	localparam int          TP_LSB          = 0;
	localparam int          TP_W            = 3;
	localparam logic [2:0]  TP_RST          = 3'h0;
	localparam int          TMO_W           = 5;
	localparam logic [4:0]  GNT_TIMEOUT     = 5'h10;
	localparam int          PRE_W           = 7;
	localparam logic [1:0]  PRI_BACKOFF     = 2'h2;
endpackage : pba_pkg

/* hdl/pba_rr_pick.sv */
// Rotating picker: first request after the last winner
module pba_rr_pick #(
	parameter int N = 10,
	parameter int W = 4
) (
	input  wire logic [N-1:0] req_vec,
	input  wire logic [W-1:0] last_idx,
	output logic              found,
	output logic [W-1:0]      pick_idx
);
	always_comb begin
		int j;
		j = 0;
		found = 1'b0;
		pick_idx = '0;
		// Descending so the nearest follower of last_idx wins
		for (int i = N; i >= 1; i--) begin
			j = int'(last_idx) + i;
			if (j >= N) begin
				j = j - N;
			end
			if (req_vec[j]) begin
				found = 1'b1;
				pick_idx = W'(j);
			end
		end
	end
endmodule : pba_rr_pick

/* hdl/pba_cnt.sv */
// Saturating cycle counter with synchronous clear
module pba_cnt #(
	parameter int W = 5
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic         clear,
	input  wire logic         inc,
	output logic [W-1:0]      count
);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (inc && count != {W{1'b1}}) begin
			count <= count + W'(1);
		end
	end
endmodule : pba_cnt

/* bench/pba_master_model.sv */
// Behavioural secondary bus masters, the bridge initiator included
module pba_master_model (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic [9:0] want,
	input  wire logic       hold,
	input  wire logic [8:0] gnt_n,
	input  wire logic       bridge_gnt,
	output logic      [8:0] req_n,
	output logic            bridge_req,
	output logic            frame_n,
	output logic            irdy_n,
	output logic      [3:0] who
);
	logic [9:0] g;
	logic [3:0] idx;
	logic [1:0] ph;
	// Unused requests idle high; in external mode bit 0 is the grant, low active
	assign req_n = ~want[8:0];
	assign bridge_req = want[9];
	assign g = {bridge_gnt, ~gnt_n} & want;
	always_comb begin
		idx = 4'hF;
		for (int i = 0; i < 10; i++) begin
			if (g[i]) begin
				idx = 4'(i);
			end
		end
	end
	// One address phase, one data phase, then the bus is idle again
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ph <= 2'h0;
			frame_n <= 1'h1;
			irdy_n <= 1'h1;
			who <= 4'hF;
		end else if (ph == 2'h0) begin
			if (!hold && g != 10'h000) begin
				ph <= 2'h1;
				frame_n <= 1'h0;
				who <= idx;
			end
		end else if (ph == 2'h1) begin
			ph <= 2'h2;
			frame_n <= 1'h1;
			irdy_n <= 1'h0;
		end else begin
			ph <= 2'h0;
			irdy_n <= 1'h1;
		end
	end
endmodule : pba_master_model

/* bench/tb_top.sv */
// Self-checking bench for the arbiter and parking block
`define CHK(nm, e, s) begin \
	n_tests++; \
	if ((s) !== (e)) begin \
		num_errors++; \
		$display("BAD %s exp %0h got %0h", nm, e, s); \
	end \
end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk;
	logic        rstn;
	logic        cfn_n;
	logic [9:0]  want;
	logic        hold;
	logic [8:0]  req_n;
	logic [8:0]  gnt_n;
	logic        frame_n;
	logic        irdy_n;
	logic        b_req;
	logic        b_gnt;
	logic [3:0]  who;
	logic [2:0]  s_oe;
	logic        pend;
	logic        tend;
	logic        p_gnt_n;
	logic        p_req_n;
	logic        p_fs;
	logic [2:0]  p_oe;
	logic [7:0]  ra;
	logic [31:0] wd;
	logic        wr;
	logic        rd;
	logic [31:0] rdat;
	int          num_errors;
	int          n_tests;

	pba_arbiter DUT (
		.sys_clk(sys_clk), .rstn(rstn), .central_function_sel_n(cfn_n),
		.sec_req_n(req_n), .sec_gnt_n(gnt_n), .sec_frame_n(frame_n),
		.sec_initiator_ready_n(irdy_n), .bridge_sec_req(b_req), .bridge_sec_gnt(b_gnt),
		.sec_ad_oe(s_oe[2]), .sec_cbe_oe(s_oe[1]), .sec_par_oe(s_oe[0]),
		.pri_pending(pend), .pri_target_end(tend), .pri_gnt_n(p_gnt_n),
		.pri_frame_n(1'h1), .pri_irdy_n(1'h1), .pri_req_n(p_req_n),
		.pri_frame_start(p_fs), .pri_ad_oe(p_oe[2]), .pri_cmd_byte_en_oe(p_oe[1]),
		.pri_parity_oe(p_oe[0]), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdat)
	);

	pba_master_model partner (
		.sys_clk(sys_clk), .rstn(rstn), .want(want), .hold(hold), .gnt_n(gnt_n),
		.bridge_gnt(b_gnt), .req_n(req_n), .bridge_req(b_req), .frame_n(frame_n),
		.irdy_n(irdy_n), .who(who)
	);

	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic end_sim();
		if (num_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	task automatic do_reset(input logic c);
		@(posedge sys_clk);
		rstn <= 1'h0;
		cfn_n <= c;
		want <= 10'h000;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'h1;
		cyc(2);
	endtask : do_reset

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr <= 1'h1;
		ra <= a;
		wd <= d;
		@(posedge sys_clk);
		wr <= 1'h0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge sys_clk);
		rd <= 1'h1;
		ra <= a;
		@(posedge sys_clk);
		rd <= 1'h0;
		#1;
		`CHK(nm, e, rdat)
	endtask : reg_read

	task automatic t_regs();
		`CHK("park at reset", 1'h1, b_gnt)
		reg_read(8'h40, 32'h00000200, "prio");
		reg_read(8'h48, 32'h00000000, "park");
		reg_read(8'h4C, 32'h00000000, "preempt");
		reg_read(8'h44, 32'h00000000, "unmapped");
		reg_read(8'h50, 32'h00000019, "status");
		reg_write(8'h4C, 32'h80000006);
		reg_read(8'h4C, 32'h80000006, "preempt");
		reg_write(8'h48, 32'h00000002);
		reg_read(8'h48, 32'h00000002, "park");
		reg_write(8'h48, 32'h00000000);
		reg_write(8'h4C, 32'h00000000);
	endtask : t_regs

	task automatic t_drop();
		int n;
		@(posedge sys_clk);
		want <= 10'h001;
		cyc(1);
		`CHK("idle gap", 10'h1FF, {b_gnt, gnt_n})
		cyc(1);
		`CHK("new grant", 9'h1FE, gnt_n)
		n = 0;
		while (n < 40 && gnt_n[0] === 1'h0) begin
			cyc(1);
			n++;
		end
		`CHK("timeout", 1'h1, n >= 16 && n <= 18)
		@(posedge sys_clk);
		want <= 10'h000;
		cyc(2);
	endtask : t_drop

	task automatic t_rot(input logic [9:0] prio, input logic flat);
		logic [3:0] w [12];
		int k;
		reg_write(8'h40, {22'h000000, prio});
		k = 0;
		@(posedge sys_clk);
		hold <= 1'h0;
		want <= 10'h3FF;
		for (int c = 0; c < 300 && k < 12; c++) begin
			cyc(1);
			if (frame_n === 1'h0) begin
				w[k] = who;
				k++;
			end
		end
		`CHK("starts", 12, k)
		if (k < 12) begin
			end_sim();
		end
		for (k = 1; k < 12; k++) begin
			if (flat) `CHK("flat turn", (w[k-1] + 1) % 10, w[k])
			else if (w[k-1] != 9) `CHK("bridge turn", 9, w[k])
			else if (k > 1) `CHK("low turn", (w[k-2] + 1) % 9, w[k])
		end
		@(posedge sys_clk);
		hold <= 1'h1;
		want <= 10'h000;
		cyc(4);
	endtask : t_rot

	task automatic t_pri();
		@(posedge sys_clk);
		pend <= 1'h1;
		cyc(1);
		`CHK("pri req", 1'h0, p_req_n)
		@(posedge sys_clk);
		tend <= 1'h1;
		@(posedge sys_clk);
		tend <= 1'h0;
		#1;
		`CHK("backoff", 1'h1, p_req_n)
		cyc(1);
		`CHK("backoff", 1'h1, p_req_n)
		cyc(1);
		`CHK("backoff end", 1'h0, p_req_n)
		@(posedge sys_clk);
		p_gnt_n <= 1'h0;
		pend <= 1'h0;
		cyc(1);
		`CHK("no park", 3'h0, p_oe)
		cyc(1);
		`CHK("park ad", 3'h6, p_oe)
		cyc(1);
		`CHK("park par", 3'h7, p_oe)
		@(posedge sys_clk);
		pend <= 1'h1;
		cyc(1);
		`CHK("start parked", 1'h1, p_fs)
		@(posedge sys_clk);
		pend <= 1'h0;
		cyc(3);
		@(posedge sys_clk);
		p_gnt_n <= 1'h1;
		cyc(1);
		`CHK("release", 3'h0, p_oe)
	endtask : t_pri

	task automatic t_ext();
		@(posedge sys_clk);
		want <= 10'h200;
		cyc(1);
		`CHK("ext req", 9'h1FE, gnt_n)
		@(posedge sys_clk);
		want <= 10'h201;
		cyc(1);
		`CHK("ext start", 1'h1, b_gnt)
		@(posedge sys_clk);
		want <= 10'h001;
		cyc(1);
		`CHK("ext park", 3'h6, s_oe)
		cyc(1);
		`CHK("ext park par", 3'h7, s_oe)
	endtask : t_ext

	initial begin
		num_errors = 0;
		n_tests = 0;
		rstn = 1'h0;
		cfn_n = 1'h0;
		want = 10'h000;
		hold = 1'h1;
		pend = 1'h0;
		tend = 1'h0;
		p_gnt_n = 1'h1;
		ra = 8'h00;
		wd = 32'h00000000;
		wr = 1'h0;
		rd = 1'h0;
		do_reset(1'h0);
		t_regs();
		t_drop();
		t_rot(10'h200, 1'h0);
		t_rot(10'h3FF, 1'h1);
		t_pri();
		do_reset(1'h1);
		t_ext();
		end_sim();
	end
endmodule : tb_top
